// ---- inc/ocma_pkg.sv ----
package ocma_pkg;
	// Channel and monitor counts
	localparam int NUM_CH = 12;
	localparam int NUM_MON = 6;
	localparam int DIAG_W = 16;
	localparam int SET_W = 3;
	localparam int BW_W = 2;
	localparam int SEL_W = 4;
	localparam int ADR_W = 3;
	localparam int CNT_W = 8;

	// Monitored attribute slots; the receiver reads input power in slot 1
	localparam int MON_BIAS = 0;
	localparam int MON_POWER = 1;
	localparam int MON_TEMP = 2;
	localparam int MON_VCC33 = 3;
	localparam int MON_VCC25 = 4;
	localparam int MON_OPTIME = 5;

	// Read selector codes on the link read port
	localparam logic [SEL_W-1:0] SEL_LOS = 4'h0;
	localparam logic [SEL_W-1:0] SEL_FLT = 4'h1;
	localparam logic [SEL_W-1:0] SEL_ALM = 4'h2;
	localparam logic [SEL_W-1:0] SEL_DIAG0 = 4'h4;
	localparam logic [SEL_W-1:0] SEL_DIAG5 = 4'h9;

	// Reset values of the control registers
	localparam logic [NUM_CH-1:0] CH_RST = 12'h000;
	localparam logic [SET_W-1:0] SET_RST = 3'h0;
	localparam logic [BW_W-1:0] BW_RST = 2'h0;
	localparam logic [NUM_MON-1:0] MALM_RST = 6'h00;
	localparam logic PMODE_RST = 1'b0;

	// Interrupt pulse width
	localparam int CLK_PERIOD_NS = 10;
	localparam int INT_PULSE_NS = 1000;
	localparam int INT_PULSE_CYC =
		(INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] INT_PULSE_LD = CNT_W'(INT_PULSE_CYC);

	// Link side read sequencer
	typedef enum logic [1:0]
	{
		OCMA_LNK_IDLE = 2'b01,
		OCMA_LNK_WAIT = 2'b10
	} ocma_lnk_e;
endpackage

// ---- hdl/ocma_evt_xfer.sv ----
`timescale 1ns/100ps
// Carries a one-cycle event from one clock domain to another by toggle.
// Events closer together than three destination cycles may merge.
module ocma_evt_xfer
(
	// Source domain
	input wire logic src_clk,
	input wire logic src_rst,
	input wire logic src_pulse,
	// Destination domain
	input wire logic dst_clk,
	input wire logic dst_rst,
	output logic dst_pulse
);
	typedef struct packed
	{
		logic tgl;
	} ocma_src_s;

	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
	} ocma_dst_s;

	ocma_src_s src_q, src_d;
	ocma_dst_s dst_q, dst_d;

	// Flip the toggle once per event
	always_comb
	begin
		src_d = src_q;
		src_d.tgl = src_q.tgl ^ src_pulse;
		if (src_rst)
			src_d = '0;
	end

	always_ff @(posedge src_clk)
		src_q <= src_d;

	// Two stages before the edge detector looks at it
	always_comb
	begin
		dst_d = dst_q;
		dst_d.s1 = src_q.tgl;
		dst_d.s2 = dst_q.s1;
		dst_d.s3 = dst_q.s2;
		if (dst_rst)
			dst_d = '0;
	end

	always_ff @(posedge dst_clk)
		dst_q <= dst_d;

	assign dst_pulse = dst_q.s2 ^ dst_q.s3;
endmodule

// ---- hdl/ocma_ctrl_alarm.sv ----
`timescale 1ns/100ps
// Contract
// - Twelve channels, each with own controls/status
// - Address, reset and interrupt pins provided
// - Out-of-threshold attribute sets flag and interrupt
// - Transmitter: input loss and fault flag
// - Receiver: optical input loss flags
// - Flags latch until host clears them
// - Reading a flag group clears it; maskable
// - Interrupt selectable as pulse or level
// - Transmitter squelches lost channel unless disabled
// - Transmitter disables on fault or deactivation
// - Receiver squelches on loss or deactivation
// - Transmitter per-channel controls incl. equalization
// - Receiver per-channel amplitude, de-emphasis, bandwidth
// - Module reset restores control defaults
// - Transmitter diagnostics readable over serial port
// - Receiver diagnostics readable over serial port
// - Device answers only as serial slave
module ocma_ctrl_alarm
#(
	parameter bit IS_RX = 1'b0
)
(
	// Core clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial link clock and reset
	input wire logic link_clk,
	input wire logic link_rst,
	// Dedicated pins
	input wire logic mod_rst_n_pin,
	input wire logic [ocma_pkg::ADR_W-1:0] mod_addr_pin,
	output logic int_out,
	output logic int_oe_n,
	output logic [ocma_pkg::ADR_W-1:0] dev_addr,
	// Channel status pins
	input wire logic [ocma_pkg::NUM_CH-1:0] ch_los_pin,
	input wire logic [ocma_pkg::NUM_CH-1:0] ch_fault_pin,
	// Monitor values and thresholds
	input wire logic [ocma_pkg::NUM_MON-1:0][ocma_pkg::DIAG_W-1:0] diag_val,
	input wire logic [ocma_pkg::NUM_MON-1:0][ocma_pkg::DIAG_W-1:0] thr_hi,
	input wire logic [ocma_pkg::NUM_MON-1:0][ocma_pkg::DIAG_W-1:0] thr_lo,
	// Control write from the serial slave
	input wire logic cfg_we,
	input wire logic [ocma_pkg::NUM_CH-1:0] cfg_pol_inv,
	input wire logic [ocma_pkg::NUM_CH-1:0] cfg_deact,
	input wire logic [ocma_pkg::NUM_CH-1:0] cfg_margin,
	input wire logic [ocma_pkg::NUM_CH-1:0] cfg_sq_dis,
	input wire logic [ocma_pkg::NUM_CH-1:0][ocma_pkg::SET_W-1:0] cfg_eq,
	input wire logic [ocma_pkg::NUM_CH-1:0][ocma_pkg::SET_W-1:0] cfg_amp,
	input wire logic [ocma_pkg::NUM_CH-1:0][ocma_pkg::SET_W-1:0] cfg_deemph,
	input wire logic [ocma_pkg::NUM_CH-1:0][ocma_pkg::BW_W-1:0] cfg_bw,
	input wire logic [ocma_pkg::NUM_CH-1:0] cfg_mask_los,
	input wire logic [ocma_pkg::NUM_CH-1:0] cfg_mask_flt,
	input wire logic [ocma_pkg::NUM_MON-1:0] cfg_mask_alm,
	input wire logic cfg_pulse_mode,
	// Channel controls out
	output logic [ocma_pkg::NUM_CH-1:0] ch_pol_inv,
	output logic [ocma_pkg::NUM_CH-1:0] ch_margin,
	output logic [ocma_pkg::NUM_CH-1:0][ocma_pkg::SET_W-1:0] ch_eq,
	output logic [ocma_pkg::NUM_CH-1:0][ocma_pkg::SET_W-1:0] ch_amp,
	output logic [ocma_pkg::NUM_CH-1:0][ocma_pkg::SET_W-1:0] ch_deemph,
	output logic [ocma_pkg::NUM_CH-1:0][ocma_pkg::BW_W-1:0] ch_bw,
	output logic [ocma_pkg::NUM_CH-1:0] ch_squelch,
	output logic [ocma_pkg::NUM_CH-1:0] ch_disable,
	// Latched flag view
	output logic [ocma_pkg::NUM_CH-1:0] los_flags,
	output logic [ocma_pkg::NUM_CH-1:0] flt_flags,
	output logic [ocma_pkg::NUM_MON-1:0] alm_flags,
	// Link read port
	input wire logic link_rd_req,
	input wire logic [ocma_pkg::SEL_W-1:0] link_rd_sel,
	output logic link_rd_ready,
	output logic link_rd_valid,
	output logic [ocma_pkg::DIAG_W-1:0] link_rd_data
);
	import ocma_pkg::*;

	typedef struct packed
	{
		logic rstn_s1;
		logic rstn_s2;
		logic [ADR_W-1:0] adr_s1;
		logic [ADR_W-1:0] adr_s2;
		logic [NUM_CH-1:0] los_s1;
		logic [NUM_CH-1:0] los_s2;
		logic [NUM_CH-1:0] flt_s1;
		logic [NUM_CH-1:0] flt_s2;
		logic [NUM_CH-1:0] pol;
		logic [NUM_CH-1:0] deact;
		logic [NUM_CH-1:0] margin;
		logic [NUM_CH-1:0] sqdis;
		logic [NUM_CH-1:0][SET_W-1:0] eq;
		logic [NUM_CH-1:0][SET_W-1:0] amp;
		logic [NUM_CH-1:0][SET_W-1:0] deemph;
		logic [NUM_CH-1:0][BW_W-1:0] bw;
		logic [NUM_CH-1:0] m_los;
		logic [NUM_CH-1:0] m_flt;
		logic [NUM_MON-1:0] m_alm;
		logic pmode;
		logic [NUM_CH-1:0] los_f;
		logic [NUM_CH-1:0] flt_f;
		logic [NUM_MON-1:0] alm_f;
		logic [NUM_CH-1:0] sq;
		logic [NUM_CH-1:0] dis;
		logic [CNT_W-1:0] pcnt;
		logic int_q;
		logic rd_done;
		logic [DIAG_W-1:0] snap;
	} ocma_core_s;

	typedef struct packed
	{
		ocma_lnk_e st;
		logic [SEL_W-1:0] sel;
		logic [DIAG_W-1:0] data;
		logic valid;
	} ocma_link_s;

	ocma_core_s q, n;
	ocma_link_s lq, ln;
	logic rd_evt;
	logic ack_evt;
	logic req_go;
	logic [NUM_MON-1:0] alm_hit;
	logic [NUM_CH-1:0] set_flt;
	logic [NUM_CH-1:0] clr_los;
	logic [NUM_CH-1:0] clr_flt;
	logic [NUM_MON-1:0] clr_alm;
	logic new_evt;
	logic any_q;

	// Window compare per monitored attribute
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MON; gi++)
		begin : g_mon
			assign alm_hit[gi] = (diag_val[gi] > thr_hi[gi]) ||
				(diag_val[gi] < thr_lo[gi]);
		end
	endgenerate

	// Fault sensing exists only on the transmitter
	assign set_flt = IS_RX ? CH_RST : q.flt_s2;

	// Read of a group clears exactly that group
	assign clr_los = (rd_evt && lq.sel == SEL_LOS) ? '1 : '0;
	assign clr_flt = (rd_evt && lq.sel == SEL_FLT) ? '1 : '0;
	assign clr_alm = (rd_evt && lq.sel == SEL_ALM) ? '1 : '0;

	// Only an unmasked flag going from clear to set counts as a new event
	assign new_evt = |(q.los_s2 & ~q.los_f & ~q.m_los) |
		|(set_flt & ~q.flt_f & ~q.m_flt) |
		|(alm_hit & ~q.alm_f & ~q.m_alm);
	assign any_q = |(q.los_f & ~q.m_los) | |(q.flt_f & ~q.m_flt) |
		|(q.alm_f & ~q.m_alm);

	// Core next state
	always_comb
	begin
		n = q;
		n.rstn_s1 = mod_rst_n_pin;
		n.rstn_s2 = q.rstn_s1;
		n.adr_s1 = mod_addr_pin;
		n.adr_s2 = q.adr_s1;
		n.los_s1 = ch_los_pin;
		n.los_s2 = q.los_s1;
		n.flt_s1 = ch_fault_pin;
		n.flt_s2 = q.flt_s1;
		// Set wins over a clear in the same cycle
		n.los_f = (q.los_f & ~clr_los) | q.los_s2;
		n.flt_f = (q.flt_f & ~clr_flt) | set_flt;
		n.alm_f = (q.alm_f & ~clr_alm) | alm_hit;
		if (cfg_we)
		begin
			n.pol = cfg_pol_inv;
			n.deact = cfg_deact;
			n.margin = IS_RX ? CH_RST : cfg_margin;
			n.sqdis = cfg_sq_dis;
			n.m_los = cfg_mask_los;
			n.m_flt = cfg_mask_flt;
			n.m_alm = cfg_mask_alm;
			n.pmode = cfg_pulse_mode;
			for (int i = 0; i < NUM_CH; i++)
			begin
				n.eq[i] = IS_RX ? SET_RST : cfg_eq[i];
				n.amp[i] = IS_RX ? cfg_amp[i] : SET_RST;
				n.deemph[i] = IS_RX ? cfg_deemph[i] : SET_RST;
				n.bw[i] = IS_RX ? cfg_bw[i] : BW_RST;
			end
		end
		// Output gating follows the live loss state, not the latched flag
		if (IS_RX)
		begin
			n.sq = (q.los_s2 & ~q.sqdis) | q.deact;
			n.dis = q.deact;
		end
		else
		begin
			n.sq = q.los_s2 & ~q.sqdis;
			n.dis = q.flt_s2 | q.deact;
		end
		// Pulse timer restarts on each new event
		if (new_evt)
			n.pcnt = INT_PULSE_LD;
		else if (q.pcnt != '0)
			n.pcnt = q.pcnt - CNT_W'(1);
		// Level taken from the next flags here, so no loop through a net
		n.int_q = n.pmode ? (n.pcnt != '0) :
			(|(n.los_f & ~n.m_los) | |(n.flt_f & ~n.m_flt) |
			|(n.alm_f & ~n.m_alm));
		// Snapshot is taken before the clear lands
		n.rd_done = rd_evt;
		if (rd_evt)
		begin
			n.snap = '0;
			if (lq.sel == SEL_LOS)
				n.snap[NUM_CH-1:0] = q.los_f;
			else if (lq.sel == SEL_FLT)
				n.snap[NUM_CH-1:0] = q.flt_f;
			else if (lq.sel == SEL_ALM)
				n.snap[NUM_MON-1:0] = q.alm_f;
			else if (lq.sel >= SEL_DIAG0 && lq.sel <= SEL_DIAG5)
				n.snap = diag_val[lq.sel - SEL_DIAG0];
		end
		// Module reset pin returns controls and flags to defaults
		if (!q.rstn_s2)
		begin
			n.pol = CH_RST;
			n.deact = CH_RST;
			n.margin = CH_RST;
			n.sqdis = CH_RST;
			n.m_los = CH_RST;
			n.m_flt = CH_RST;
			n.m_alm = MALM_RST;
			n.pmode = PMODE_RST;
			n.los_f = CH_RST;
			n.flt_f = CH_RST;
			n.alm_f = MALM_RST;
			n.sq = CH_RST;
			n.dis = CH_RST;
			n.pcnt = '0;
			n.int_q = 1'b0;
			for (int i = 0; i < NUM_CH; i++)
			begin
				n.eq[i] = SET_RST;
				n.amp[i] = SET_RST;
				n.deemph[i] = SET_RST;
				n.bw[i] = BW_RST;
			end
		end
		if (rst)
			n = '0;
	end

	always_ff @(posedge clk)
		q <= n;

	// Link side: one read outstanding at a time, device only answers
	assign req_go = link_rd_req && (lq.st == OCMA_LNK_IDLE);

	always_comb
	begin
		ln = lq;
		ln.valid = 1'b0;
		unique case (lq.st)
			OCMA_LNK_IDLE:
			begin
				if (link_rd_req)
				begin
					ln.sel = link_rd_sel;
					ln.st = OCMA_LNK_WAIT;
				end
			end
			OCMA_LNK_WAIT:
			begin
				// Snapshot holds still until the next request
				if (ack_evt)
				begin
					ln.data = q.snap;
					ln.valid = 1'b1;
					ln.st = OCMA_LNK_IDLE;
				end
			end
			default:
				ln.st = OCMA_LNK_IDLE;
		endcase
		if (link_rst)
		begin
			ln = '0;
			ln.st = OCMA_LNK_IDLE;
		end
	end

	always_ff @(posedge link_clk)
		lq <= ln;

	// Request into the core domain
	ocma_evt_xfer u_req
	(
		.src_clk(link_clk),
		.src_rst(link_rst),
		.src_pulse(req_go),
		.dst_clk(clk),
		.dst_rst(rst),
		.dst_pulse(rd_evt)
	);

	// Acknowledge back to the link domain
	ocma_evt_xfer u_ack
	(
		.src_clk(clk),
		.src_rst(rst),
		.src_pulse(q.rd_done),
		.dst_clk(link_clk),
		.dst_rst(link_rst),
		.dst_pulse(ack_evt)
	);

	// Open-drain interrupt: drive low while asserted
	assign int_out = 1'b0;
	assign int_oe_n = ~q.int_q;
	assign dev_addr = q.adr_s2;
	assign ch_pol_inv = q.pol;
	assign ch_margin = q.margin;
	assign ch_eq = q.eq;
	assign ch_amp = q.amp;
	assign ch_deemph = q.deemph;
	assign ch_bw = q.bw;
	assign ch_squelch = q.sq;
	assign ch_disable = q.dis;
	assign los_flags = q.los_f;
	assign flt_flags = q.flt_f;
	assign alm_flags = q.alm_f;
	assign link_rd_ready = (lq.st == OCMA_LNK_IDLE);
	assign link_rd_valid = lq.valid;
	assign link_rd_data = lq.data;

	// Core domain checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_latch;
		!(|clr_los) && q.rstn_s2 |=>
			(los_flags & $past(los_flags)) == $past(los_flags);
	endproperty
	a_latch: assert property (p_latch)
		else $error("loss flag dropped without a read");

	property p_los_set;
		q.rstn_s2 && |q.los_s2 |=>
			(los_flags & $past(q.los_s2)) == $past(q.los_s2);
	endproperty
	a_los_set: assert property (p_los_set)
		else $error("loss of signal not latched");

	property p_rd_clear;
		q.rstn_s2 && rd_evt && lq.sel == SEL_ALM && alm_hit == '0 |=>
			alm_flags == '0;
	endproperty
	a_rd_clear: assert property (p_rd_clear)
		else $error("alarm group not cleared by read");

	property p_alarm;
		q.rstn_s2 && |alm_hit |=>
			(alm_flags & $past(alm_hit)) == $past(alm_hit);
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("threshold crossing not flagged");

	property p_fault;
		!IS_RX && q.rstn_s2 && |q.flt_s2 |=>
			(flt_flags & $past(q.flt_s2)) == $past(q.flt_s2)
			&& (ch_disable & $past(q.flt_s2)) == $past(q.flt_s2);
	endproperty
	a_fault: assert property (p_fault)
		else $error("fault not flagged or channel not disabled");

	property p_squelch;
		q.rstn_s2 |=> ch_squelch == ($past(q.los_s2 & ~q.sqdis)
			| (IS_RX ? $past(q.deact) : CH_RST));
	endproperty
	a_squelch: assert property (p_squelch)
		else $error("squelch output wrong");

	property p_level;
		!q.pmode |-> int_oe_n == !any_q;
	endproperty
	a_level: assert property (p_level)
		else $error("level interrupt does not track flags");

	sequence s_pulse_hold;
		(!int_oe_n) [*8];
	endsequence

	property p_pulse;
		q.pmode && q.rstn_s2 && new_evt && !cfg_we |=> s_pulse_hold;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("interrupt pulse too short");

	property p_modrst;
		!q.rstn_s2 |=> ch_pol_inv == CH_RST && los_flags == CH_RST
			&& int_oe_n;
	endproperty
	a_modrst: assert property (p_modrst)
		else $error("module reset left state behind");

	// Link domain check
	sequence s_rd_wait;
		!link_rd_ready [*1] ##[1:12] link_rd_valid;
	endsequence

	property p_rd_answer;
		@(posedge link_clk) disable iff (link_rst || rst)
			req_go |=> s_rd_wait;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered in time");
endmodule

// ---- tb/ocma_host_model.sv ----
`timescale 1ns/100ps
// Link-side host; it masters every read on the link port
module ocma_host_model
(
	// Link clock
	input wire logic link_clk,
	// Read port of the device
	input wire logic link_rd_ready,
	input wire logic link_rd_valid,
	input wire logic [ocma_pkg::DIAG_W-1:0] link_rd_data,
	output logic link_rd_req,
	output logic [ocma_pkg::SEL_W-1:0] link_rd_sel
);
	import ocma_pkg::*;

	// Idle bus at time zero
	initial
	begin
		link_rd_req = 1'b0;
		link_rd_sel = 4'h0;
	end

	// One read; selector scrambled once released so nothing leans on it
	task automatic rd(input logic [SEL_W-1:0] s,
		output logic [DIAG_W-1:0] d, output bit ok);
		int n;
		ok = 1'b0;
		d = 16'h0000;
		@(posedge link_clk);
		link_rd_sel <= s;
		link_rd_req <= 1'b1;
		@(posedge link_clk);
		n = 1;
		while (link_rd_ready !== 1'b1 && n < 20)
		begin
			@(posedge link_clk);
			n++;
		end
		link_rd_req <= 1'b0;
		link_rd_sel <= ~s;
		for (n = 0; n < 20 && !ok; n++)
		begin
			@(posedge link_clk);
			if (link_rd_valid === 1'b1)
			begin
				d = link_rd_data;
				ok = 1'b1;
			end
		end
	endtask
endmodule

// ---- tb/ocma_ctrl_alarm_tb.sv ----
`timescale 1ns/100ps
// Transmitter variant, driven from pins, config port and link host
module ocma_ctrl_alarm_tb;
	import ocma_pkg::*;
	logic clk = 1'b0, rst = 1'b1, link_clk = 1'b0, link_rst = 1'b1;
	logic mod_rst_n_pin = 1'b1, cfg_we = 1'b0, cfg_pulse_mode = 1'b0;
	logic int_out, int_oe_n, link_rd_req, link_rd_ready, link_rd_valid;
	logic int_line;
	logic [ADR_W-1:0] mod_addr_pin = 3'h5, dev_addr;
	logic [NUM_CH-1:0] ch_los_pin = '0, ch_fault_pin = '0, cfg_pol_inv = '0;
	logic [NUM_CH-1:0] cfg_deact = '0, cfg_margin = 12'hfff, cfg_sq_dis = '0;
	logic [NUM_CH-1:0] cfg_mask_los = '0, cfg_mask_flt = '0;
	logic [NUM_CH-1:0] ch_pol_inv, ch_margin, ch_squelch, ch_disable;
	logic [NUM_CH-1:0] los_flags, flt_flags;
	logic [NUM_CH-1:0][SET_W-1:0] cfg_eq = {NUM_CH{3'h5}};
	logic [NUM_CH-1:0][SET_W-1:0] cfg_amp = {NUM_CH{3'h3}};
	logic [NUM_CH-1:0][SET_W-1:0] cfg_deemph = {NUM_CH{3'h6}};
	logic [NUM_CH-1:0][SET_W-1:0] ch_eq, ch_amp, ch_deemph;
	logic [NUM_CH-1:0][SET_W-1:0] rx_eq, rx_amp, rx_deemph;
	logic [NUM_CH-1:0][BW_W-1:0] cfg_bw = {NUM_CH{2'h1}}, ch_bw, rx_bw;
	logic [NUM_CH-1:0] rx_margin, rx_sq, rx_dis, rx_los, rx_flt;
	logic [NUM_MON-1:0] cfg_mask_alm = '0, alm_flags;
	logic [NUM_MON-1:0][DIAG_W-1:0] diag_val, thr_hi, thr_lo;
	logic [SEL_W-1:0] link_rd_sel;
	logic [DIAG_W-1:0] link_rd_data, rdat;
	bit ok;
	int miscompares = 0, checked = 0, n, w;

	// Clocks; edges of the two coincide every 80 ns
	always #5 clk = ~clk;
	always #16 link_clk = ~link_clk;
	// Open-drain interrupt wire with its pull-up
	assign int_line = int_oe_n ? 1'b1 : int_out;

	ocma_ctrl_alarm #(.IS_RX(1'b0)) DUT
	(
		.clk, .rst, .link_clk, .link_rst, .mod_rst_n_pin, .mod_addr_pin,
		.int_out, .int_oe_n, .dev_addr, .ch_los_pin, .ch_fault_pin,
		.diag_val, .thr_hi, .thr_lo, .cfg_we, .cfg_pol_inv, .cfg_deact,
		.cfg_margin, .cfg_sq_dis, .cfg_eq, .cfg_amp, .cfg_deemph, .cfg_bw,
		.cfg_mask_los, .cfg_mask_flt, .cfg_mask_alm, .cfg_pulse_mode,
		.ch_pol_inv, .ch_margin, .ch_eq, .ch_amp, .ch_deemph, .ch_bw,
		.ch_squelch, .ch_disable, .los_flags, .flt_flags, .alm_flags,
		.link_rd_req, .link_rd_sel, .link_rd_ready, .link_rd_valid,
		.link_rd_data
	);

	ocma_host_model HOST
	(
		.link_clk, .link_rd_ready, .link_rd_valid, .link_rd_data,
		.link_rd_req, .link_rd_sel
	);

	// Receiver variant on the same stimulus; its link port stays idle
	ocma_ctrl_alarm #(.IS_RX(1'b1)) DUT_RX
	(
		.clk, .rst, .link_clk, .link_rst, .mod_rst_n_pin, .mod_addr_pin,
		.int_out(), .int_oe_n(), .dev_addr(), .ch_los_pin, .ch_fault_pin,
		.diag_val, .thr_hi, .thr_lo, .cfg_we, .cfg_pol_inv, .cfg_deact,
		.cfg_margin, .cfg_sq_dis, .cfg_eq, .cfg_amp, .cfg_deemph, .cfg_bw,
		.cfg_mask_los, .cfg_mask_flt, .cfg_mask_alm, .cfg_pulse_mode,
		.ch_pol_inv(), .ch_margin(rx_margin), .ch_eq(rx_eq),
		.ch_amp(rx_amp), .ch_deemph(rx_deemph), .ch_bw(rx_bw),
		.ch_squelch(rx_sq), .ch_disable(rx_dis), .los_flags(rx_los),
		.flt_flags(rx_flt), .alm_flags(),
		.link_rd_req(1'b0), .link_rd_sel(4'h0), .link_rd_ready(),
		.link_rd_valid(), .link_rd_data()
	);

	// Compare and count
	task automatic chk(input string nm, input logic [35:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Outputs are looked at on the falling edge, well after updates
	task automatic look(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask

	// Whole control block loaded in one strobe
	task automatic wcfg(input logic [NUM_CH-1:0] pol, dea, sqd, mflt,
		input logic pm);
		@(posedge clk);
		cfg_pol_inv <= pol;
		cfg_deact <= dea;
		cfg_sq_dis <= sqd;
		cfg_mask_flt <= mflt;
		cfg_pulse_mode <= pm;
		cfg_we <= 1'b1;
		@(posedge clk);
		cfg_we <= 1'b0;
	endtask

	// Link read; a lost answer ends the run
	task automatic rd(input logic [SEL_W-1:0] s, input logic [35:0] exp);
		HOST.rd(s, rdat, ok);
		if (!ok)
		begin
			miscompares++;
			finish_test();
		end
		else
			chk("link_rd_data", rdat, exp);
	endtask

	task automatic finish_test();
		$display("Counts: %0d checks, %0d mismatches", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Pin drive helper: one change, then let it settle
	task automatic pins(input logic [NUM_CH-1:0] l, f, input int k);
		@(posedge clk);
		ch_los_pin <= l;
		ch_fault_pin <= f;
		look(k);
	endtask

	initial
	begin
		for (int i = 0; i < NUM_MON; i++)
		begin
			diag_val[i] = 16'h1000 + 16'(i);
			thr_hi[i] = 16'h8000;
			thr_lo[i] = 16'h0100;
		end
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		link_rst <= 1'b0;
		look(4);
		chk("int_line", int_line, 1'b1);
		chk("ch_pol_inv", ch_pol_inv, 12'h000);
		chk("los_flags", los_flags, 12'h000);
		chk("dev_addr", dev_addr, 3'h5);
		$display("Test reset done");

		wcfg(12'ha5c, 12'h004, 12'h020, 12'h200, 1'b0);
		look(2);
		chk("ch_pol_inv", ch_pol_inv, 12'ha5c);
		chk("ch_margin", ch_margin, 12'hfff);
		chk("ch_eq", ch_eq, {NUM_CH{3'h5}});
		chk("ch_amp", ch_amp, 36'h0);
		chk("ch_disable", ch_disable, 12'h004);
		chk("ch_deemph", ch_deemph, 36'h0);
		chk("ch_bw", ch_bw, 24'h0);
		chk("rx_amp", rx_amp, {NUM_CH{3'h3}});
		chk("rx_deemph", rx_deemph, {NUM_CH{3'h6}});
		chk("rx_bw", rx_bw, {NUM_CH{2'h1}});
		chk("rx_eq", rx_eq, 36'h0);
		chk("rx_margin", rx_margin, 12'h000);
		chk("rx_squelch", rx_sq, 12'h004);
		$display("Test controls done");

		pins(12'h028, 12'h000, 5);
		chk("los_flags", los_flags, 12'h028);
		chk("ch_squelch", ch_squelch, 12'h008);
		chk("rx_los", rx_los, 12'h028);
		chk("rx_squelch", rx_sq, 12'h00c);
		chk("int_line", int_line, 1'b0);
		pins(12'h000, 12'h000, 5);
		chk("los_flags", los_flags, 12'h028);
		rd(SEL_LOS, 16'h0028);
		look(3);
		chk("los_flags", los_flags, 12'h000);
		chk("int_line", int_line, 1'b1);
		$display("Test loss done");

		pins(12'h000, 12'h200, 5);
		chk("flt_flags", flt_flags, 12'h200);
		chk("int_line", int_line, 1'b1);
		chk("ch_disable", ch_disable, 12'h204);
		chk("rx_flt", rx_flt, 12'h000);
		chk("rx_disable", rx_dis, 12'h004);
		pins(12'h000, 12'h080, 5);
		chk("int_line", int_line, 1'b0);
		pins(12'h000, 12'h000, 4);
		rd(SEL_FLT, 16'h0280);
		look(3);
		chk("int_line", int_line, 1'b1);
		$display("Test fault done");

		@(posedge clk);
		diag_val[MON_TEMP] <= 16'h9000;
		diag_val[MON_VCC25] <= 16'h0050;
		look(3);
		chk("alm_flags", alm_flags, 6'h14);
		@(posedge clk);
		diag_val[MON_TEMP] <= 16'h1002;
		diag_val[MON_VCC25] <= 16'h1004;
		look(3);
		rd(SEL_ALM, 16'h0014);
		rd(4'h3, 16'h0000);
		for (int i = 0; i < NUM_MON; i++)
			rd(SEL_DIAG0 + 4'(i), 16'h1000 + 16'(i));
		$display("Test alarm done");

		wcfg(12'h000, 12'h000, 12'h000, 12'h000, 1'b1);
		pins(12'h001, 12'h000, 0);
		for (n = 0; int_line !== 1'b0 && n < 20; n++)
			look(1);
		for (w = 0; int_line === 1'b0 && w < 300; w++)
			look(1);
		// A pulse that never starts or never ends is a hang
		if (n == 20 || w == 300)
		begin
			miscompares++;
			finish_test();
		end
		else
			chk("pulse_len", w, INT_PULSE_CYC);
		pins(12'h000, 12'h000, 4);
		rd(SEL_LOS, 16'h0001);
		$display("Test pulse done");

		wcfg(12'h0f0, 12'h000, 12'h000, 12'h000, 1'b0);
		look(2);
		chk("ch_pol_inv", ch_pol_inv, 12'h0f0);
		@(posedge clk);
		mod_rst_n_pin <= 1'b0;
		look(4);
		chk("ch_pol_inv", ch_pol_inv, 12'h000);
		wcfg(12'h0f0, 12'h000, 12'h000, 12'h000, 1'b0);
		look(2);
		chk("ch_pol_inv", ch_pol_inv, 12'h000);
		@(posedge clk);
		mod_rst_n_pin <= 1'b1;
		look(4);
		chk("ch_pol_inv", ch_pol_inv, 12'h000);
		$display("Test module reset done");
		finish_test();
	end
endmodule
